// file: bench/asf_status_chk.sv
// Concurrent checks on the ports of the status block
`timescale 1ns/10ps
module asf_status_chk
	import asf_pkg::*;
(
	// Clock, reset, enable
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic ce_in,
	// Bus handshake
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic avs_waitrequest_out,
	// Configuration and events
	input wire logic [1:0] seq_mode_in,
	input wire logic [1:0] cal_type_in,
	input wire logic single_cycle_select_in,
	input wire logic result_write_in,
	input wire logic gain_cal_done_in,
	input wire logic gain_cal_overrange_in,
	// Status outputs
	input wire asf_pkg::asf_power_type power_state_out,
	input wire logic gain_saturate_out,
	input wire logic ready_interrupt_pin_n_out,
	input wire logic irq_out
);
	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (rst_in);

	// Bus answers after exactly one wait state and only for one cycle
	a_wait_one_cycle: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
		&& ce_in |=> !avs_waitrequest_out) else $error("waitrequest late");
	a_wait_short: assert property (!avs_waitrequest_out && ce_in |=> avs_waitrequest_out)
		else $error("waitrequest low too long");
	// Leaving reset shows reset state, then standby
	a_reset_exit: assert property ($fell(rst_in) && $past(ce_in) && ce_in |->
		power_state_out == ASF_PS_RESET && avs_waitrequest_out && ready_interrupt_pin_n_out
		&& !irq_out ##1 power_state_out == ASF_PS_STANDBY) else $error("reset exit wrong");
	// Configuration errors keep the device out of conversion
	a_cal_standby: assert property ((ce_in && cal_type_in == 2'h3) [*4]
		|-> power_state_out != ASF_PS_CONVERT) else $error("converting with bad cal type");
	a_cycle_standby: assert property ((ce_in && seq_mode_in != 2'h0
		&& !single_cycle_select_in) [*4] |-> power_state_out != ASF_PS_CONVERT)
		else $error("converting with bad single cycle select");
	// Ready pin follows new results in mode 1 only
	a_ready_mode: assert property ((ce_in && seq_mode_in != 2'h0) [*4]
		|-> ready_interrupt_pin_n_out) else $error("ready pin low outside mode 1");
	a_ready_set: assert property (ce_in && seq_mode_in == 2'h0 && result_write_in
		|-> ##[1:3] !ready_interrupt_pin_n_out) else $error("ready pin not asserted");
	// Gain saturation follows the last calibration outcome
	a_sat_set: assert property (ce_in && gain_cal_done_in && gain_cal_overrange_in
		|-> ##[1:2] gain_saturate_out) else $error("gain saturation not set");
	a_sat_clear: assert property (ce_in && gain_cal_done_in && !gain_cal_overrange_in
		|-> ##[1:2] !gain_saturate_out) else $error("gain saturation not cleared");

	c_read: cover property (avs_read_in && !avs_waitrequest_out);
	c_ready: cover property (!ready_interrupt_pin_n_out);
	c_irq: cover property (irq_out);
endmodule : asf_status_chk

bind asf_status asf_status_chk u_asf_status_chk (.clock_in, .rst_in, .ce_in, .avs_read_in,
	.avs_write_in, .avs_waitrequest_out, .seq_mode_in, .cal_type_in, .single_cycle_select_in,
	.result_write_in, .gain_cal_done_in, .gain_cal_overrange_in, .power_state_out,
	.gain_saturate_out, .ready_interrupt_pin_n_out, .irq_out);

// file: bench/asf_status_tb.sv
// Self-checking bench of the status block
`timescale 1ns/10ps
module asf_status_tb;
	import asf_pkg::*;
	logic clock_in = 0, rst_in = 1, ce_in = 1, avs_read_in = 0, avs_write_in = 0;
	logic [7:0] avs_address_in = 8'h00;
	logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, r;
	logic [3:0] avs_byteenable_in = 4'hf, result_rate_in = 4'h0;
	logic [1:0] seq_mode_in = 2'h0, cal_type_in = 2'h0;
	logic single_cycle_select_in = 1, conversion_start_in = 0, conversion_running_in = 0;
	logic calibration_running_in = 0, gain_cal_done_in = 0, gain_cal_overrange_in = 0;
	logic result_write_in = 0, result_clipped_in = 0, fifo_read_done_in = 0;
	logic ref_low_in = 0, analog_overrange_in = 0, avs_waitrequest_out, conversion_allowed_out;
	logic gain_saturate_out, ready_interrupt_pin_n_out, irq_out;
	logic [5:0] channel_scan_enable_in = 6'h0, channel_output_enable_in = 6'h0;
	logic [17:0] channel_scan_order_in = 18'h0, channel_output_map_in = 18'h0;
	asf_power_type power_request_in = ASF_PS_STANDBY, power_state_out;
	logic [31:0] exp_q[$], msk_q[$];
	int fail_count = 0, samples_checked = 0;

	// Free running clock
	always #10 clock_in = ~clock_in;

	asf_status u_asf_status (.clock_in, .rst_in, .ce_in, .avs_address_in, .avs_read_in,
		.avs_write_in, .avs_writedata_in, .avs_byteenable_in, .avs_readdata_out,
		.avs_waitrequest_out, .seq_mode_in, .cal_type_in, .single_cycle_select_in,
		.channel_scan_enable_in, .channel_scan_order_in, .channel_output_enable_in,
		.channel_output_map_in, .power_request_in, .conversion_start_in,
		.conversion_running_in, .calibration_running_in, .gain_cal_done_in,
		.gain_cal_overrange_in, .result_write_in, .result_clipped_in, .result_rate_in,
		.fifo_read_done_in, .ref_low_in, .analog_overrange_in, .power_state_out,
		.conversion_allowed_out, .gain_saturate_out, .ready_interrupt_pin_n_out, .irq_out);

	task automatic check(input logic [31:0] seen, input logic [31:0] expv);
		samples_checked++;
		if (seen !== expv)
		begin
			fail_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, expv);
		end
	endtask : check

	task automatic results();
		if (exp_q.size() > 0)
			fail_count++;
		$display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : results

	// One bus transfer, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clock_in);
		n = 0;
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_read_in <= !wr;
		avs_write_in <= wr;
		do
		begin
			@(posedge clock_in);
			n++;
		end
		while (avs_waitrequest_out !== 1'b0 && n < 50);
		avs_read_in <= 0;
		avs_write_in <= 0;
		if (n >= 50)
		begin
			fail_count++;
			results();
		end
	endtask : bus

	// Read with the expected value noted for the watcher
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		exp_q.push_back(e);
		msk_q.push_back(m);
		bus(0, a, 32'h0);
	endtask : rd

	// One-cycle event pulse: result, fifo read, gain cal, conversion start
	task automatic pulse(input logic [3:0] v);
		@(posedge clock_in);
		{result_write_in, fifo_read_done_in, gain_cal_done_in, conversion_start_in} <= v;
		@(posedge clock_in);
		{result_write_in, fifo_read_done_in, gain_cal_done_in, conversion_start_in} <= 4'h0;
		repeat (4) @(posedge clock_in);
	endtask : pulse

	// Apply a configuration, then read error flags and power state
	task automatic cfg(input logic [1:0] m, c, input logic s, input logic [5:0] en,
		input logic [17:0] o, input logic [5:0] oe, input logic [17:0] mp, input logic [31:0] e);
		@(posedge clock_in);
		{seq_mode_in, cal_type_in, single_cycle_select_in} <= {m, c, s};
		{channel_scan_enable_in, channel_scan_order_in} <= {en, o};
		{channel_output_enable_in, channel_output_map_in} <= {oe, mp};
		repeat (5) @(posedge clock_in);
		rd(8'h00, 32'h380c, e);
	endtask : cfg

	// Watcher: compares each read answer with the oldest note
	always @(posedge clock_in)
		if (avs_read_in === 1'b1 && avs_waitrequest_out === 1'b0 && exp_q.size() > 0)
			check(avs_readdata_out & msk_q.pop_front(), exp_q.pop_front());

	// Overall cycle limit
	initial
	begin
		repeat (20000) @(posedge clock_in);
		fail_count++;
		results();
	end

	// Main sequence
	initial
	begin
		void'($urandom(27898));
		repeat (2) @(posedge clock_in);
		rst_in <= 0;
		rd(8'h00, 32'h7fff, 32'h0008);
		rd(8'h0c, 32'hf, 32'h0);
		rd(8'h40, 32'hffffffff, 32'h0);
		power_request_in <= ASF_PS_RESET;
		bus(1, 8'h00, 32'h7fff);
		rd(8'h00, 32'h7fff, 32'h0008);
		power_request_in <= ASF_PS_SLEEP;
		repeat (4) @(posedge clock_in);
		rd(8'h00, 32'h400c, 32'h0004);
		power_request_in <= ASF_PS_CONVERT;
		cfg(2'h0, 2'h3, 1, 6'h0, 18'h0, 6'h0, 18'h0, 32'h0808);
		check({31'h0, conversion_allowed_out}, 32'h0);
		for (int i = 1; i < 4; i++)
			cfg(2'(i), 2'h0, 0, 6'h07, 18'h0d1, 6'h0, 18'h0, 32'h0808);
		cfg(2'h1, 2'h0, 1, 6'h07, 18'h089, 6'h0, 18'h0, 32'h2008);
		cfg(2'h0, 2'h0, 1, 6'h07, 18'h089, 6'h0, 18'h0, 32'h0000);
		cfg(2'h1, 2'h0, 1, 6'h07, 18'h011, 6'h0, 18'h0, 32'h2008);
		cfg(2'h1, 2'h0, 1, 6'h01, 18'h007, 6'h0, 18'h0, 32'h2008);
		cfg(2'h1, 2'h0, 1, 6'h07, 18'h111, 6'h0, 18'h0, 32'h2008);
		cfg(2'h1, 2'h0, 1, 6'h07, 18'h0d1, 6'h03, 18'h0, 32'h1008);
		cfg(2'h0, 2'h0, 1, 6'h07, 18'h0d1, 6'h03, 18'h0, 32'h0000);
		cfg(2'h1, 2'h0, 1, 6'h07, 18'h0d1, 6'h03, 18'h008, 32'h0000);
		cfg(2'h0, 2'h0, 1, 6'h0, 18'h0, 6'h0, 18'h0, 32'h0000);
		rd(8'h00, 32'h400c, 32'h4000);
		ref_low_in <= 1;
		repeat (6) @(posedge clock_in);
		rd(8'h00, 32'h400c, 32'h0000);
		check({31'h0, conversion_allowed_out}, 32'h1);
		ref_low_in <= 0;
		pulse(4'h1);
		rd(8'h10, 32'h1, 32'h0);
		repeat (1500) @(posedge clock_in);
		rd(8'h10, 32'h1, 32'h1);
		for (int i = 0; i < 4; i++)
		begin
			{conversion_running_in, calibration_running_in} <= 2'(i);
			repeat (3) @(posedge clock_in);
			rd(8'h00, 32'h2, {30'h0, i != 0, 1'b0});
		end
		for (int i = 0; i < 4; i++)
		begin
			r = $urandom;
			analog_overrange_in <= r[0];
			repeat (5) @(posedge clock_in);
			rd(8'h00, 32'h100, {23'h0, r[0], 8'h0});
		end
		bus(1, 8'h08, 32'hf);
		bus(1, 8'h0c, 32'h5);
		rd(8'h04, 32'hf, 32'h0);
		for (int i = 0; i < 3; i++)
		begin
			r = $urandom;
			result_rate_in <= r[3:0];
			result_clipped_in <= r[4];
			pulse(4'h8);
			rd(8'h00, 32'h2f1, {22'h0, r[4], 1'b0, r[3:0], 4'h1});
			check({31'h0, ready_interrupt_pin_n_out}, 32'h0);
			check({31'h0, irq_out}, 32'h1);
			pulse(4'h4);
			rd(8'h00, 32'h1, 32'h0);
		end
		rd(8'h04, 32'h1, 32'h1);
		bus(1, 8'h0c, 32'h0);
		repeat (2) @(posedge clock_in);
		check({31'h0, irq_out}, 32'h0);
		bus(1, 8'h08, 32'hf);
		rd(8'h04, 32'hf, 32'h0);
		gain_cal_overrange_in <= 1;
		pulse(4'h2);
		rd(8'h00, 32'h400, 32'h400);
		check({31'h0, gain_saturate_out}, 32'h1);
		gain_cal_overrange_in <= 0;
		pulse(4'h2);
		rd(8'h00, 32'h400, 32'h0);
		// Result pulse while the clock enable is low must leave ready clear
		ce_in <= 0;
		pulse(4'h8);
		ce_in <= 1;
		rd(8'h00, 32'h1, 32'h0);
		// Second reset in mid-run returns to standby with reference flag low
		rst_in <= 1;
		repeat (2) @(posedge clock_in);
		rst_in <= 0;
		rd(8'h00, 32'h400d, 32'h0008);
		@(posedge clock_in);
		results();
	end
endmodule : asf_status_tb

// file: src/asf_consts.svh
// Offsets, field positions, reset values and timing counts of the status block
// Function
// RULE1: Bit 14 reference present; zero below threshold or in sleep/standby.
// RULE2: Reference flag valid within 30 us after a conversion start.
// RULE3: Missing reference is status only; conversion carries on regardless.
// RULE4: Outside mode 1, duplicate orders among enabled channels set bit 13.
// RULE5: Enabled channel with order 000 or 111 also sets bit 13.
// RULE6: Enabled orders must run 1..n without gaps; error holds standby.
// RULE7: Outside mode 1, shared output among enabled outputs sets bit 12; standby.
// RULE8: Calibration type 11 sets configuration error bit 11.
// RULE9: Single-cycle select low in scan modes 2-4 sets bit 11; forces standby.
// RULE10: Overranged system gain calibration sets bit 10; coefficient saturates.
// RULE11: Clipped result sets bit 9; in-range result reads zero.
// RULE12: Bit 8 reports modulator input above reference, gain stage included.
// RULE13: Bits 7:4 give the rate of the current FIFO result or calibration.
// RULE14: Bits 3:2 power state: 00 convert, 01 sleep, 10 standby, 11 reset.
// RULE15: Bit 1 high while conversion or calibration runs, else low.
// RULE16: Mode 1: bit 0 set on new result, cleared by full read; mirrors pin.
// RULE17: Status fields are read-only; writes leave them unchanged.
`ifndef ASF_CONSTS_SVH
`define ASF_CONSTS_SVH

// Register byte offsets
`define ASF_OFF_STATUS 8'h00
`define ASF_OFF_IRQ_STATUS 8'h04
`define ASF_OFF_IRQ_CLEAR 8'h08
`define ASF_OFF_IRQ_ENABLE 8'h0c
`define ASF_OFF_REF_VALID 8'h10

// Status field positions
`define ASF_BIT_REF_PRESENT 14
`define ASF_BIT_ORDER_ERR 13
`define ASF_BIT_MAP_ERR 12
`define ASF_BIT_CFG_ERR 11
`define ASF_BIT_SYS_GAIN_OR 10
`define ASF_BIT_RESULT_OR 9
`define ASF_BIT_ANALOG_OR 8
`define ASF_RATE_HI 7
`define ASF_RATE_LO 4
`define ASF_PSTATE_HI 3
`define ASF_PSTATE_LO 2
`define ASF_BIT_BUSY 1
`define ASF_BIT_READY 0

// Interrupt event bits
`define ASF_IRQ_READY 0
`define ASF_IRQ_CFG 1
`define ASF_IRQ_RESULT_OR 2
`define ASF_IRQ_REF_LOST 3
`define ASF_IRQ_WIDTH 4

// Field encodings and reset values
`define ASF_NUM_CH 6
`define ASF_ORDER_W 3
`define ASF_CAL_RESERVED 2'h3
`define ASF_MODE_SEQ1 2'h0
`define ASF_RATE_RESET 4'h0
`define ASF_IRQ_EN_RESET 4'h0

// Reference settle time in ns and its cycle count at 20 ns, rounded down
`define ASF_REF_VALID_NS 30000
`define ASF_CLK_NS 20
`define ASF_REF_VALID_CYC (`ASF_REF_VALID_NS / `ASF_CLK_NS)

`endif

// file: src/asf_pkg.sv
// Types shared by the status block
package asf_pkg;
	// Power state, values equal to the reported field
	typedef enum logic [1:0] {
		ASF_PS_CONVERT = 2'h0,
		ASF_PS_SLEEP = 2'h1,
		ASF_PS_STANDBY = 2'h2,
		ASF_PS_RESET = 2'h3
	} asf_power_type;
endpackage : asf_pkg

// file: src/asf_status.sv
// Status flag block of the converter with Avalon-MM register access
`timescale 1ns/10ps
`include "asf_consts.svh"
module asf_status (
	// Clock, reset, enable
	input wire logic clock_in,
	input wire logic rst_in,
	input wire logic ce_in,
	// Avalon-MM slave
	input wire logic [7:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	// Configuration from control registers
	input wire logic [1:0] seq_mode_in,
	input wire logic [1:0] cal_type_in,
	input wire logic single_cycle_select_in,
	input wire logic [5:0] channel_scan_enable_in,
	input wire logic [17:0] channel_scan_order_in,
	input wire logic [5:0] channel_output_enable_in,
	input wire logic [17:0] channel_output_map_in,
	input wire asf_pkg::asf_power_type power_request_in,
	// Sequencer and datapath events
	input wire logic conversion_start_in,
	input wire logic conversion_running_in,
	input wire logic calibration_running_in,
	input wire logic gain_cal_done_in,
	input wire logic gain_cal_overrange_in,
	input wire logic result_write_in,
	input wire logic result_clipped_in,
	input wire logic [3:0] result_rate_in,
	input wire logic fifo_read_done_in,
	// Analog comparators
	input wire logic ref_low_in,
	input wire logic analog_overrange_in,
	// Status outputs
	output asf_pkg::asf_power_type power_state_out,
	output logic conversion_allowed_out,
	output logic gain_saturate_out,
	output logic ready_interrupt_pin_n_out,
	output logic irq_out
);
	import asf_pkg::*;

	logic ref_low_s1;
	logic ref_low_s2;
	logic aor_s1;
	logic aor_s2;
	asf_power_type power_state;
	asf_power_type next_power_state;
	logic reference_present;
	logic scan_order_error;
	logic output_map_error;
	logic config_error;
	logic sys_gain_overrange;
	logic result_overrange;
	logic analog_overrange;
	logic [3:0] rate;
	logic modulator_busy;
	logic ready;
	logic [11:0] ref_count;
	logic ref_valid;
	logic [3:0] irq_status;
	logic [3:0] irq_enable;
	logic [3:0] irq_event;
	logic next_order_err;
	logic next_map_err;
	logic next_cfg_err;
	logic any_error;
	logic ref_lost;
	logic [31:0] status_word;
	logic [31:0] next_readdata;
	logic req;

	// Two-stage synchronisers for analog comparator levels
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			ref_low_s1 <= 1'b0;
			ref_low_s2 <= 1'b0;
			aor_s1 <= 1'b0;
			aor_s2 <= 1'b0;
		end
		else if (ce_in)
		begin
			ref_low_s1 <= ref_low_in;
			ref_low_s2 <= ref_low_s1;
			aor_s1 <= analog_overrange_in;
			aor_s2 <= aor_s1;
		end
	end

	// Scan order check: enabled orders must be a permutation of 1..n
	always_comb
	begin
		logic [2:0] count;
		logic [2:0] oi;
		logic [2:0] oj;
		count = 3'h0;
		oi = 3'h0;
		oj = 3'h0;
		next_order_err = 1'b0;
		for (int i = 0; i < `ASF_NUM_CH; i++)
			count = count + {2'h0, channel_scan_enable_in[i]};
		for (int i = 0; i < `ASF_NUM_CH; i++)
		begin
			oi = channel_scan_order_in[i*`ASF_ORDER_W +: `ASF_ORDER_W];
			if (channel_scan_enable_in[i])
			begin
				if (oi == 3'h0 || oi == 3'h7) // [RULE5]
					next_order_err = 1'b1;
				if (oi > count) // [RULE6]
					next_order_err = 1'b1;
				for (int j = i + 1; j < `ASF_NUM_CH; j++)
				begin
					oj = channel_scan_order_in[j*`ASF_ORDER_W +: `ASF_ORDER_W];
					if (channel_scan_enable_in[j] && oi == oj) // [RULE4]
						next_order_err = 1'b1;
				end
			end
		end
		if (seq_mode_in == `ASF_MODE_SEQ1) // [RULE4]
			next_order_err = 1'b0;
	end

	// Output mapping check: no two enabled outputs share a bump
	always_comb
	begin
		logic [2:0] mi;
		logic [2:0] mj;
		mi = 3'h0;
		mj = 3'h0;
		next_map_err = 1'b0;
		for (int i = 0; i < `ASF_NUM_CH; i++)
		begin
			mi = channel_output_map_in[i*`ASF_ORDER_W +: `ASF_ORDER_W];
			for (int j = i + 1; j < `ASF_NUM_CH; j++)
			begin
				mj = channel_output_map_in[j*`ASF_ORDER_W +: `ASF_ORDER_W];
				if (channel_output_enable_in[i] && channel_output_enable_in[j] && mi == mj)
					next_map_err = 1'b1; // [RULE7]
			end
		end
		if (seq_mode_in == `ASF_MODE_SEQ1)
			next_map_err = 1'b0;
	end

	// Invalid configuration detection
	assign next_cfg_err = (cal_type_in == `ASF_CAL_RESERVED) // [RULE8]
		|| (!single_cycle_select_in && seq_mode_in != `ASF_MODE_SEQ1); // [RULE9]
	assign any_error = next_order_err || next_map_err || next_cfg_err;

	// Configuration error flags
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			scan_order_error <= 1'b0;
			output_map_error <= 1'b0;
			config_error <= 1'b0;
		end
		else if (ce_in)
		begin
			scan_order_error <= next_order_err; // [RULE4] [RULE5] [RULE6]
			output_map_error <= next_map_err; // [RULE7]
			config_error <= next_cfg_err; // [RULE8] [RULE9]
		end
	end

	// Power state selection; reference loss does not enter here
	always_comb
	begin
		case (power_state)
			ASF_PS_RESET: next_power_state = ASF_PS_STANDBY;
			default:
				if (any_error)
					next_power_state = ASF_PS_STANDBY; // [RULE6] [RULE7] [RULE9] [RULE3]
				else if (power_request_in == ASF_PS_RESET)
					next_power_state = ASF_PS_STANDBY;
				else
					next_power_state = power_request_in;
		endcase
	end

	// Power state register
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
			power_state <= ASF_PS_RESET; // [RULE14]
		else if (ce_in)
			power_state <= next_power_state; // [RULE14]
	end

	// Reference detection, forced low outside conversion
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
			reference_present <= 1'b0;
		else if (ce_in)
		begin
			if (power_state != ASF_PS_CONVERT)
				reference_present <= 1'b0; // [RULE1]
			else
				reference_present <= !ref_low_s2; // [RULE1]
		end
	end

	// Settle counter after conversion start marks the flag valid
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			ref_count <= 12'h0;
			ref_valid <= 1'b0;
		end
		else if (ce_in)
		begin
			if (power_state != ASF_PS_CONVERT || conversion_start_in)
			begin
				ref_count <= 12'h0;
				ref_valid <= 1'b0;
			end
			else if (ref_count < 12'(`ASF_REF_VALID_CYC - 1))
				ref_count <= ref_count + 12'h1;
			else
				ref_valid <= 1'b1; // [RULE2]
		end
	end

	// Calibration and result flags
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			sys_gain_overrange <= 1'b0;
			result_overrange <= 1'b0;
			rate <= `ASF_RATE_RESET;
			analog_overrange <= 1'b0;
			modulator_busy <= 1'b0;
		end
		else if (ce_in)
		begin
			if (gain_cal_done_in)
				sys_gain_overrange <= gain_cal_overrange_in; // [RULE10]
			if (result_write_in)
			begin
				result_overrange <= result_clipped_in; // [RULE11]
				rate <= result_rate_in; // [RULE13]
			end
			analog_overrange <= aor_s2; // [RULE12]
			modulator_busy <= conversion_running_in || calibration_running_in; // [RULE15]
		end
	end

	// Ready flag, mode 1 only; a new result wins over a read
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
			ready <= 1'b0;
		else if (ce_in)
		begin
			if (seq_mode_in != `ASF_MODE_SEQ1)
				ready <= 1'b0;
			else if (result_write_in)
				ready <= 1'b1; // [RULE16]
			else if (fifo_read_done_in)
				ready <= 1'b0; // [RULE16]
		end
	end

	// Interrupt events
	assign ref_lost = reference_present && ref_low_s2 && power_state == ASF_PS_CONVERT;
	assign irq_event[`ASF_IRQ_READY] = result_write_in && seq_mode_in == `ASF_MODE_SEQ1;
	assign irq_event[`ASF_IRQ_CFG] = any_error && !(scan_order_error || output_map_error
		|| config_error);
	assign irq_event[`ASF_IRQ_RESULT_OR] = result_write_in && result_clipped_in;
	assign irq_event[`ASF_IRQ_REF_LOST] = ref_lost;

	// Status word; upper bits read as zero
	always_comb
	begin
		status_word = 32'h0;
		status_word[`ASF_BIT_REF_PRESENT] = reference_present;
		status_word[`ASF_BIT_ORDER_ERR] = scan_order_error;
		status_word[`ASF_BIT_MAP_ERR] = output_map_error;
		status_word[`ASF_BIT_CFG_ERR] = config_error;
		status_word[`ASF_BIT_SYS_GAIN_OR] = sys_gain_overrange;
		status_word[`ASF_BIT_RESULT_OR] = result_overrange;
		status_word[`ASF_BIT_ANALOG_OR] = analog_overrange;
		status_word[`ASF_RATE_HI:`ASF_RATE_LO] = rate;
		status_word[`ASF_PSTATE_HI:`ASF_PSTATE_LO] = power_state;
		status_word[`ASF_BIT_BUSY] = modulator_busy;
		status_word[`ASF_BIT_READY] = ready;
	end

	// Read data decode
	assign req = (avs_read_in || avs_write_in) && avs_waitrequest_out;
	always_comb
	begin
		if (avs_address_in == `ASF_OFF_STATUS)
			next_readdata = status_word;
		else if (avs_address_in == `ASF_OFF_IRQ_STATUS)
			next_readdata = {28'h0, irq_status};
		else if (avs_address_in == `ASF_OFF_IRQ_ENABLE)
			next_readdata = {28'h0, irq_enable};
		else if (avs_address_in == `ASF_OFF_REF_VALID)
			next_readdata = {31'h0, ref_valid};
		else
			next_readdata = 32'h0;
	end

	// Bus handshake: one wait cycle, then data and waitrequest low
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			avs_waitrequest_out <= 1'b1;
			avs_readdata_out <= 32'h0;
		end
		else if (ce_in)
		begin
			avs_waitrequest_out <= !req;
			if (req && avs_read_in)
				avs_readdata_out <= next_readdata;
		end
	end

	// Interrupt enable register; status word writes are dropped
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
			irq_enable <= `ASF_IRQ_EN_RESET;
		else if (ce_in && req && avs_write_in && avs_byteenable_in[0]
			&& avs_address_in == `ASF_OFF_IRQ_ENABLE)
			irq_enable <= avs_writedata_in[3:0]; // [RULE17]
	end

	// Sticky interrupt status, set wins over clear
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
			irq_status <= 4'h0;
		else if (ce_in)
		begin
			if (req && avs_write_in && avs_byteenable_in[0]
				&& avs_address_in == `ASF_OFF_IRQ_CLEAR)
				irq_status <= (irq_status & ~avs_writedata_in[3:0]) | irq_event;
			else
				irq_status <= irq_status | irq_event;
		end
	end

	// Registered outputs
	always_ff @(posedge clock_in)
	begin
		if (rst_in)
		begin
			power_state_out <= ASF_PS_RESET;
			conversion_allowed_out <= 1'b0;
			gain_saturate_out <= 1'b0;
			ready_interrupt_pin_n_out <= 1'b1;
			irq_out <= 1'b0;
		end
		else if (ce_in)
		begin
			power_state_out <= next_power_state; // [RULE14]
			conversion_allowed_out <= next_power_state == ASF_PS_CONVERT; // [RULE3]
			gain_saturate_out <= gain_cal_done_in ? gain_cal_overrange_in
				: gain_saturate_out; // [RULE10]
			ready_interrupt_pin_n_out <= !(seq_mode_in == `ASF_MODE_SEQ1
				&& (result_write_in || (ready && !fifo_read_done_in))); // [RULE16]
			irq_out <= |(irq_status & irq_enable);
		end
	end
endmodule : asf_status
